// *** hw/caor_pkg.sv ***
// Contract
// - One 8-bit register, port 0x90, read/write differ.
// - Bit 7 write enables processor cycles; read reports.
// - Reset clears processor-cycle enable bit.
// - Bit 6 write forces arbitrate, processor owns.
// - Read bit 6 shows NMI arbitration mask.
// - Bit 5 selects 750 ns versus 375 ns.
// - Extended arbitration off after reset.
// - Read bit 5 shows bus time-out.
// - Time-out cleared by writing bit 6 zero, reset.
// - Written bits 3 to 0 are ignored.
// - Read bits 3 to 0 give last granted level.
// - Burst past 7.8 us after preempt: time-out.
// - Levels are 4 bits; lower wins; F processor.
package caor_pkg;
  localparam logic [15:0] ARB_OPT_PORT = 16'h0090;
  localparam int BIT_CPU_EN = 7;
  localparam int BIT_MASK = 6;
  localparam int BIT_EXT = 5;
  localparam logic [3:0] LEVEL_CPU = 4'hF;
  localparam int CLK_MHZ = 25;
  localparam int CLK_PERIOD_NS = 40;
  localparam int ARB_MIN_NS = 375;
  localparam int ARB_EXT_NS = 750;
  localparam int TIMEOUT_NS = 7800;
  // Least times round up to whole cycles.
  localparam int ARB_MIN_CYC = (ARB_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ARB_EXT_CYC = (ARB_EXT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMEOUT_CYC = TIMEOUT_NS / CLK_PERIOD_NS;
endpackage

// *** hw/caor_sync.sv ***
`timescale 1ns/1ps
module caor_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] q_reg;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= '0;
      q_reg <= '0;
    end else begin
      s1_reg <= d;
      q_reg <= s1_reg;
    end
  end

  assign q = q_reg;
endmodule // caor_sync

// *** hw/caor_top.sv ***
`timescale 1ns/1ps
module caor_top #(
  parameter int TIMEOUT_CYCLES = caor_pkg::TIMEOUT_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_sel,
  input wire logic burst_n,
  input wire logic preempt_n,
  input wire logic grant_state,
  input wire logic [3:0] priority_bus,
  output logic arbitrate_or_grant_line,
  output logic cpu_cycles_enable,
  output logic ext_arbitration,
  output logic [7:0] arb_min_cycles,
  output logic nmi
);
  logic [5:0] pins_s;
  logic burst_act;
  logic preempt_act;
  logic grant_s;
  logic [3:0] level_s;
  logic hit;
  logic wr_hit;

  // --------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------
  caor_sync #(.WIDTH(6)) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .d({~burst_n, ~preempt_n, grant_state, 3'h0}),
    .q(pins_s)
  );
  assign burst_act = pins_s[5];
  assign preempt_act = pins_s[4];
  assign grant_s = pins_s[3];

  caor_sync #(.WIDTH(4)) u_sync_lvl (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .d(priority_bus),
    .q(level_s)
  );

  // --------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------
  logic cpu_en_reg, cpu_en_next;
  logic mask_reg, mask_next;
  logic ext_reg, ext_next;
  logic tout_reg, tout_next;
  logic nmi_mask_reg, nmi_mask_next;
  logic [3:0] level_reg, level_next;
  logic [12:0] cnt_reg, cnt_next;
  logic [7:0] rdata_reg, rdata_next;

  assign hit = (io_addr == caor_pkg::ARB_OPT_PORT);
  assign wr_hit = hit && io_wr;
  assign io_sel = hit && (io_wr || io_rd);

  always_comb begin
    cpu_en_next = cpu_en_reg;
    mask_next = mask_reg;
    ext_next = ext_reg;
    tout_next = tout_reg;
    nmi_mask_next = nmi_mask_reg;
    level_next = level_reg;
    cnt_next = cnt_reg;
    rdata_next = rdata_reg;
    if (wr_hit) begin
      // Bits 4 to 0 of a write are discarded.
      cpu_en_next = io_wdata[caor_pkg::BIT_CPU_EN];
      ext_next = io_wdata[caor_pkg::BIT_EXT];
      mask_next = io_wdata[caor_pkg::BIT_MASK];
      if (!io_wdata[caor_pkg::BIT_MASK]) begin
        tout_next = 1'b0;
        nmi_mask_next = 1'b0;
      end
    end
    // Latch the owner's level while the grant is held.
    if (grant_s) begin
      level_next = level_s;
    end
    // Burst watchdog counts while preempt and burst overlap under a held grant, until a time-out.
    if (burst_act && preempt_act && grant_s && !tout_reg) begin
      if (cnt_reg >= 13'(TIMEOUT_CYCLES)) begin
        // A time-out wins over a same-cycle clearing write.
        tout_next = 1'b1;
        nmi_mask_next = 1'b1;
        mask_next = 1'b1;
        cnt_next = '0;
      end else begin
        cnt_next = cnt_reg + 13'h0001;
      end
    end else begin
      cnt_next = '0;
    end
    if (hit && io_rd) begin
      rdata_next = {cpu_en_reg, nmi_mask_reg, tout_reg, 1'b0,
                    level_reg};
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cpu_en_reg <= 1'b0;
      mask_reg <= 1'b0;
      ext_reg <= 1'b0;
      tout_reg <= 1'b0;
      nmi_mask_reg <= 1'b0;
      level_reg <= caor_pkg::LEVEL_CPU;
      cnt_reg <= '0;
      rdata_reg <= 8'h00;
    end else begin
      cpu_en_reg <= cpu_en_next;
      mask_reg <= mask_next;
      ext_reg <= ext_next;
      tout_reg <= tout_next;
      nmi_mask_reg <= nmi_mask_next;
      level_reg <= level_next;
      cnt_reg <= cnt_next;
      rdata_reg <= rdata_next;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  // High means arbitrate; the mask keeps the processor as owner.
  assign arbitrate_or_grant_line = mask_reg || tout_reg;
  assign nmi = tout_reg;
  assign cpu_cycles_enable = cpu_en_reg;
  assign ext_arbitration = ext_reg;
  assign arb_min_cycles = ext_reg ? 8'(caor_pkg::ARB_EXT_CYC)
                                  : 8'(caor_pkg::ARB_MIN_CYC);
  assign io_rdata = rdata_reg;
endmodule // caor_top

// *** tb/caor_asserts.sv ***
`timescale 1ns/1ps
module caor_asserts (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic burst_n,
  input wire logic arbitrate_or_grant_line,
  input wire logic cpu_cycles_enable,
  input wire logic ext_arbitration,
  input wire logic [7:0] arb_min_cycles,
  input wire logic nmi
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  wire w = io_wr && io_addr == 16'h0090;
  wire r = io_rd && io_addr == 16'h0090;
  cpu_en_a: assert property (
    w |=> cpu_cycles_enable == $past(io_wdata[7])) else $error("cpu bit");
  ext_sel_a: assert property (
    w |=> ext_arbitration == $past(io_wdata[5])) else $error("ext bit");
  min_cyc_a: assert property (
    arb_min_cycles == (ext_arbitration ? 8'h13 : 8'h0A)) else $error("min");
  read_back_a: assert property (
    r |=> io_rdata[7] == $past(cpu_cycles_enable) && !io_rdata[4]
      && io_rdata[5] == $past(nmi)) else $error("read byte");
  force_arb_a: assert property (
    w && io_wdata[6] |=> arbitrate_or_grant_line) else $error("mask");
  tout_arb_a: assert property (
    nmi |-> arbitrate_or_grant_line) else $error("time-out grant");
  tout_clr_a: assert property (
    w && !io_wdata[6] && burst_n && $past(burst_n) && $past(burst_n, 2)
      |=> !nmi) else $error("time-out clear");
  reset_val_a: assert property (
    $rose(nrst) |-> !cpu_cycles_enable && !ext_arbitration && !nmi)
    else $error("reset values");
endmodule // caor_asserts
bind caor_top caor_asserts u_caor_asserts (.clk_sys, .nrst, .io_addr,
  .io_wr, .io_rd, .io_wdata, .io_rdata, .burst_n, .arbitrate_or_grant_line,
  .cpu_cycles_enable, .ext_arbitration, .arb_min_cycles, .nmi);

// *** tb/caor_tb_top.sv ***
`timescale 1ns/1ps
module caor_tb_top;
  logic clk_sys, nrst, io_wr, io_rd, burst_n, preempt_n, grant_state;
  logic io_sel, arbitrate_or_grant_line, cpu_cycles_enable;
  logic ext_arbitration, nmi;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata, arb_min_cycles, d;
  logic [3:0] priority_bus, l;
  int num_checks, miscompares, cyc;
  caor_top #(.TIMEOUT_CYCLES(20)) u_caor_top (.clk_sys, .nrst, .io_addr,
    .io_wr, .io_rd, .io_wdata, .io_rdata, .io_sel, .burst_n, .preempt_n,
    .grant_state, .priority_bus, .arbitrate_or_grant_line,
    .cpu_cycles_enable, .ext_arbitration, .arb_min_cycles, .nmi);
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (++cyc == 3000) begin
    miscompares++;
    print_verdict();
  end
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    io_wr <= wr;
    io_rd <= !wr;
    io_addr <= {8'h00, a};
    io_wdata <= v;
    #1;
    chk({7'h00, io_sel}, {7'h00, a == 8'h90});
    @(posedge clk_sys);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] rb(input logic [2:0] f, input logic [3:0] v);
    return {f, 1'b0, v};
  endfunction
  task print_verdict;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    {clk_sys, nrst, io_wr, io_rd, grant_state} = 5'h00;
    {burst_n, preempt_n} = 2'h3;
    io_addr = 16'h0090;
    io_wdata = 8'h00;
    priority_bus = 4'h0;
    void'($urandom(32'h46a4));
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    acc(0, 8'h90, 8'h00);
    chk(io_rdata, rb(3'h0, 4'hF));
    for (int i = 0; i < 12; i++) begin
      d = (i == 0) ? 8'hFF : 8'($urandom);
      acc(1, 8'h90, d);
      // A neighbouring port must not alias onto the register.
      acc(1, 8'h91, ~d);
      chk(arb_min_cycles, d[5] ? 8'h13 : 8'h0A);
      acc(0, 8'h90, 8'h00);
      chk(io_rdata, rb({d[7], 2'b00}, 4'hF));
    end
    acc(1, 8'h90, 8'h00);
    l = 4'($urandom);
    grant_state <= 1'b1;
    priority_bus <= l;
    burst_n <= 1'b0;
    preempt_n <= 1'b0;
    repeat (30) @(posedge clk_sys);
    chk({6'h00, nmi, arbitrate_or_grant_line}, 8'h03);
    {burst_n, preempt_n, grant_state} <= 3'h6;
    acc(0, 8'h90, 8'h00);
    chk(io_rdata, rb(3'h3, l));
    acc(1, 8'h90, 8'hA0);
    acc(0, 8'h90, 8'h00);
    chk(io_rdata, rb(3'h4, l));
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    acc(0, 8'h90, 8'h00);
    chk(io_rdata, rb(3'h0, 4'hF));
    print_verdict();
  end
endmodule // caor_tb_top
